// ---- hdl/blsi_pkg.sv ----
/*
 * Shared constants and types of the bit logic sequence input unit:
 * register offsets, instruction word layout, opcodes, flag positions,
 * interrupt bits and reset values.
 * Assumes a 32-bit APB register bus and a 16-bit built-in I/O word.
 */
package blsi_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int IMG_W = 16;
    localparam int SLOT_W = 3;
    localparam int SLOTS = 8;
    localparam int INSTR_W = 15;
    localparam int FLAG_W = 12;
    localparam int IRQ_W = 3;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_INSTR = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_FLAGS = 8'h08;
    localparam logic [7:0] OFS_IMG_IN = 8'h0C;
    localparam logic [7:0] OFS_IMG_OUT = 8'h10;
    localparam logic [7:0] OFS_WORK = 8'h14;
    localparam logic [7:0] OFS_REFRESH = 8'h18;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

    // ****************************************
    // Condition flag positions in the flag register
    // ****************************************
    localparam int FLG_ERROR = 0;
    localparam int FLG_ACCESS_ERROR = 1;
    localparam int FLG_CARRY = 2;
    localparam int FLG_GREATER = 3;
    localparam int FLG_EQUAL = 4;
    localparam int FLG_LESS = 5;
    localparam int FLG_NEGATIVE = 6;
    localparam int FLG_OVERFLOW = 7;
    localparam int FLG_UNDERFLOW = 8;
    localparam int FLG_GREATER_EQUAL = 9;
    localparam int FLG_NOT_EQUAL = 10;
    localparam int FLG_LESS_EQUAL = 11;
    localparam int FLG_ALWAYS_ON = 12;
    localparam int FLG_ALWAYS_OFF = 13;

    // Interrupt status bit positions
    localparam int IRQ_DONE = 0;
    localparam int IRQ_BAD = 1;
    localparam int IRQ_REFRESH = 2;

    // ****************************************
    // Instruction word
    // ****************************************
    typedef enum logic [2:0] {
        OP_LOAD = 3'b000,
        OP_LOAD_INV = 3'b001,
        OP_SERIES = 3'b010,
        OP_SERIES_INV = 3'b011,
        OP_PAR = 3'b100,
        OP_PAR_INV = 3'b101,
        OP_COIL = 3'b110,
        OP_COIL_INV = 3'b111
    } blsi_op_e;

    typedef enum logic [1:0] {
        EDGE_NONE = 2'b00,
        EDGE_UP = 2'b01,
        EDGE_DOWN = 2'b10,
        EDGE_BAD = 2'b11
    } blsi_edge_e;

    typedef enum logic [1:0] {
        AREA_IN = 2'b00,
        AREA_OUT = 2'b01,
        AREA_WORK = 2'b10,
        AREA_EXP = 2'b11
    } blsi_area_e;

    // Bit 14..12 slot, 11..8 bit, 7..6 area, 5 imm, 4..3 edge, 2..0 op
    typedef struct packed {
        logic [SLOT_W-1:0] slot;
        logic [3:0] bit_idx;
        blsi_area_e area;
        logic imm;
        blsi_edge_e edge_mode;
        blsi_op_e op;
    } blsi_instr_s;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [IMG_W-1:0] IMG_RST = 16'h0000;
    localparam logic [FLAG_W-1:0] FLAG_RST = 12'h000;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
    localparam logic [SLOTS-1:0] EDGE_RST = 8'h00;

endpackage : blsi_pkg

// ---- hdl/blsi_edge_if.sv ----
/*
 * Carrier between the sequencer core and its edge history store.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

interface blsi_edge_if;
    import blsi_pkg::*;

    logic we;
    logic [SLOT_W-1:0] slot;
    logic wr_val;
    logic prev;

    modport core (output we, output slot, output wr_val, input prev);
    modport store (input we, input slot, input wr_val, output prev);
endinterface : blsi_edge_if

`default_nettype wire

// ---- hdl/blsi_edge_store.sv ----
/*
 * Previous-scan operand history, one bit per edge instruction slot.
 * Assumes the core writes a slot only when it executes that slot.
 */
`timescale 1ns/100ps
`default_nettype none

module blsi_edge_store (
    input wire logic mclk,
    input wire logic resetn,
    blsi_edge_if.store e
);
    import blsi_pkg::*;

    typedef struct packed {
        logic [SLOTS-1:0] prev;
    } blsi_hist_s;

    blsi_hist_s q;
    blsi_hist_s d;

    // Read old state, store new operand value
    always_comb begin
        d = q;
        if (e.we) begin
            d.prev[e.slot] = e.wr_val;
        end
    end

    assign e.prev = q.prev[e.slot];

    // History starts OFF at power-up
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            q.prev <= EDGE_RST;
        end else begin
            q <= d;
        end
    end
endmodule : blsi_edge_store

`default_nettype wire

// ---- hdl/blsi_top.sv ----
/*
 * Bit logic sequence input unit: executes load, series, parallel
 * contact and coil instructions written over APB, with edge and
 * immediate-refresh variants, and keeps the condition flags.
 * Assumes din is synchronous to mclk; one APB write to the
 * instruction register is one executed instruction, and a write to
 * the refresh register is the end-of-scan cyclic I/O refresh.
 */
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module blsi_top (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [blsi_pkg::ADDR_W-1:0] paddr,
    input wire logic [blsi_pkg::DATA_W-1:0] pwdata,
    output logic [blsi_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [blsi_pkg::IMG_W-1:0] din,
    output logic [blsi_pkg::IMG_W-1:0] dout,
    output logic irq
);
    import blsi_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic exec;
        logic bad;
        logic [INSTR_W-1:0] last;
        logic [IMG_W-1:0] in_img;
        logic [IMG_W-1:0] out_img;
        logic [IMG_W-1:0] work;
        logic [IMG_W-1:0] dout;
        logic [FLAG_W-1:0] flags;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic irq;
        logic pready;
        logic pslverr;
        logic [DATA_W-1:0] prdata;
    } blsi_core_s;

    blsi_core_s q;
    blsi_core_s d;

    // ****************************************
    // Helpers
    // ****************************************

    // Replace one byte of an image with the same byte of a source
    function automatic logic [IMG_W-1:0] merge_byte(
        input logic [IMG_W-1:0] img,
        input logic [IMG_W-1:0] src,
        input logic hi
    );
        logic [IMG_W-1:0] r;
        r = img;
        if (hi) begin
            r[15:8] = src[15:8];
        end else begin
            r[7:0] = src[7:0];
        end
        return r;
    endfunction : merge_byte

    // Pick one operand bit from its area
    function automatic logic pick_bit(
        input blsi_area_e area,
        input logic [3:0] idx,
        input logic [IMG_W-1:0] in_v,
        input logic [IMG_W-1:0] out_v,
        input logic [IMG_W-1:0] work_v
    );
        logic r;
        r = 1'b0;
        unique case (area)
            AREA_IN: r = in_v[idx];
            AREA_OUT: r = out_v[idx];
            AREA_WORK: r = work_v[idx];
            AREA_EXP: r = 1'b0;
        endcase
        return r;
    endfunction : pick_bit

    // Register map membership of a bus address
    function automatic logic is_mapped(
        input logic [ADDR_W-1:0] a
    );
        logic r;
        r = 1'b0;
        unique case (a)
            OFS_INSTR, OFS_STATUS, OFS_FLAGS: r = 1'b1;
            OFS_IMG_IN, OFS_IMG_OUT, OFS_WORK: r = 1'b1;
            OFS_REFRESH, OFS_IRQ_STAT, OFS_IRQ_MASK: r = 1'b1;
            default: r = 1'b0;
        endcase
        return r;
    endfunction : is_mapped

    // Read data of one register, zero outside the map
    function automatic logic [DATA_W-1:0] read_word(
        input logic [ADDR_W-1:0] a,
        input blsi_core_s s
    );
        logic [DATA_W-1:0] r;
        r = 32'h0000_0000;
        unique case (a)
            OFS_INSTR: r = {17'h0_0000, s.last};
            OFS_STATUS: r = {30'h0000_0000, s.bad, s.exec};
            OFS_FLAGS: r = {18'h0_0000, 1'b0, 1'b1, s.flags};
            OFS_IMG_IN: r = {16'h0000, s.in_img};
            OFS_IMG_OUT: r = {16'h0000, s.out_img};
            OFS_WORK: r = {16'h0000, s.work};
            OFS_IRQ_STAT: r = {29'h0000_0000, s.irq_stat};
            OFS_IRQ_MASK: r = {29'h0000_0000, s.irq_mask};
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction : read_word

    // ****************************************
    // Bus decode
    // ****************************************
    logic acc;
    logic commit;
    logic hit;
    logic exec_wr;

    // Access phase, commit edge and address match
    assign acc = psel && penable;
    assign commit = acc && q.pready;
    assign hit = is_mapped(paddr);
    assign exec_wr = commit && pwrite && (paddr == OFS_INSTR);

    // ****************************************
    // Instruction decode
    // ****************************************
    blsi_instr_s ins;
    logic is_coil;
    logic is_inv;
    logic edge_cap;
    logic legal;
    logic edge_ok;
    logic area_ok;
    logic imm_ok;
    logic [IMG_W-1:0] in_v;
    logic opv;
    logic cv;
    logic cres;

    // History carrier, ahead of the edge logic that reads it
    blsi_edge_if u_edge_if();

    assign ins = blsi_instr_s'(pwdata[INSTR_W-1:0]);

    // Kind of instruction
    assign is_coil = (ins.op == OP_COIL) || (ins.op == OP_COIL_INV);
    assign is_inv = (ins.op == OP_LOAD_INV) || (ins.op == OP_SERIES_INV) ||
                    (ins.op == OP_PAR_INV);
    assign edge_cap = (ins.op == OP_LOAD) || (ins.op == OP_SERIES) ||
                      (ins.op == OP_PAR);

    // Edge forms only on plain load, series and parallel
    assign edge_ok = (ins.edge_mode == EDGE_NONE) ||
                     (edge_cap && ins.edge_mode != EDGE_BAD);

    // No expansion points; coils never take the input area as target
    assign area_ok = (ins.area != AREA_EXP) &&
                     !(is_coil && ins.area == AREA_IN);

    // Immediate contacts read input pins, immediate coils drive outputs
    assign imm_ok = !ins.imm || (is_coil ? ins.area == AREA_OUT
                                         : ins.area == AREA_IN);

    // Rejected words change no image, condition or history; they set last, bad and the bad event
    assign legal = edge_ok && area_ok && imm_ok;

    // Fresh byte for any immediate word, contact or coil, image otherwise
    assign in_v = ins.imm ? merge_byte(q.in_img, din, ins.bit_idx[3])
                          : q.in_img;

    assign opv = pick_bit(ins.area, ins.bit_idx, in_v, q.out_img, q.work);

    // Contact value after edge or inversion
    always_comb begin
        cv = is_inv ? !opv : opv;
        unique case (ins.edge_mode)
            EDGE_UP: cv = opv && !u_edge_if.prev;
            EDGE_DOWN: cv = !opv && u_edge_if.prev;
            EDGE_NONE: cv = is_inv ? !opv : opv;
            EDGE_BAD: cv = 1'b0;
        endcase
    end

    // Coil result from the current condition
    assign cres = (ins.op == OP_COIL_INV) ? !q.exec : q.exec;

    // ****************************************
    // Edge history
    // ****************************************
    // Every edge instance stores its operand each execution
    assign u_edge_if.we = exec_wr && legal &&
                          (ins.edge_mode != EDGE_NONE);
    assign u_edge_if.slot = ins.slot;
    assign u_edge_if.wr_val = opv;

    blsi_edge_store u_store (
        .mclk(mclk),
        .resetn(resetn),
        .e(u_edge_if.store)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic [IRQ_W-1:0] ev;
        logic clr;
        ev = '0;
        clr = 1'b0;
        d = q;
        d.pready = 1'b0;
        d.pslverr = 1'b0;

        // One wait state, then answer with data or error
        if (acc && !q.pready) begin
            d.pready = 1'b1;
            d.pslverr = !hit;
            d.prdata = read_word(paddr, q);
        end

        // Reads of the interrupt status register clear it
        if (commit && !pwrite && paddr == OFS_IRQ_STAT) begin
            clr = 1'b1;
        end

        // Register writes take effect at the commit edge
        if (commit && pwrite && hit) begin
            unique case (paddr)
                OFS_FLAGS: d.flags = pwdata[FLAG_W-1:0];
                OFS_WORK: d.work = pwdata[IMG_W-1:0];
                OFS_IRQ_MASK: d.irq_mask = pwdata[IRQ_W-1:0];
                OFS_REFRESH: begin
                    d.in_img = din;
                    d.dout = q.out_img;
                    ev[IRQ_REFRESH] = 1'b1;
                end
                default: d.flags = q.flags;
            endcase
        end

        // Instruction execution; flags are never touched here
        if (exec_wr) begin
            d.last = pwdata[INSTR_W-1:0];
            d.bad = !legal;
            if (legal) begin
                d.in_img = in_v;
                ev[IRQ_DONE] = 1'b1;
                unique case (ins.op)
                    OP_LOAD: d.exec = cv;
                    OP_LOAD_INV: d.exec = cv;
                    OP_SERIES: d.exec = q.exec && cv;
                    OP_SERIES_INV: d.exec = q.exec && cv;
                    OP_PAR: d.exec = q.exec || cv;
                    OP_PAR_INV: d.exec = q.exec || cv;
                    OP_COIL, OP_COIL_INV: begin
                        if (ins.area == AREA_OUT) begin
                            d.out_img[ins.bit_idx] = cres;
                        end else begin
                            d.work[ins.bit_idx] = cres;
                        end
                        if (ins.imm) begin
                            d.dout = merge_byte(q.dout, d.out_img,
                                                ins.bit_idx[3]);
                        end
                    end
                endcase
            end else begin
                ev[IRQ_BAD] = 1'b1;
            end
        end

        // Sticky events; a new event beats the read clear
        d.irq_stat = (clr ? '0 : q.irq_stat) | ev;
        d.irq = |(d.irq_stat & d.irq_mask);
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            q.exec <= 1'b0;
            q.bad <= 1'b0;
            q.last <= '0;
            q.in_img <= IMG_RST;
            q.out_img <= IMG_RST;
            q.work <= IMG_RST;
            q.dout <= IMG_RST;
            q.flags <= FLAG_RST;
            q.irq_stat <= '0;
            q.irq_mask <= IRQ_MASK_RST;
            q.irq <= 1'b0;
            q.pready <= 1'b0;
            q.pslverr <= 1'b0;
            q.prdata <= '0;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flops
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign dout = q.dout;
    assign irq = q.irq;
endmodule : blsi_top

`default_nettype wire

// ---- tb/blsi_monitor.sv ----
/*
 * Port checker for blsi_top, bound to every instance.
 * Assumes one wait state on APB and din synchronous to mclk.
 */
`timescale 1ns/100ps
`default_nettype none
module blsi_monitor (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [blsi_pkg::ADDR_W-1:0] paddr,
    input wire logic [blsi_pkg::DATA_W-1:0] pwdata,
    input wire logic [blsi_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [blsi_pkg::IMG_W-1:0] dout,
    input wire logic irq
);
    import blsi_pkg::*;
    logic done_c;
    // ****
    // Transfer completion and bus checks
    // ****
    assign done_c = psel && penable && pready;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    property p_one_wait;
        $rose(psel && penable) |-> !pready ##1 pready;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("pready not after one wait state");
    property p_ready_pulse;
        pready |-> psel && penable ##1 !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready outside access or too long");
    property p_err_data;
        pslverr |-> pready && prdata == 32'h0;
    endproperty
    a_err_data: assert property (p_err_data) else $error("error response malformed");
    property p_unmapped;
        done_c && (paddr > OFS_IRQ_MASK || paddr[1:0] != 2'h0) |-> pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_mapped;
        done_c && paddr <= OFS_IRQ_MASK && paddr[1:0] == 2'h0 |-> !pslverr;
    endproperty
    a_mapped: assert property (p_mapped) else $error("mapped access refused");
    property p_const_flags;
        done_c && !pwrite && paddr == OFS_FLAGS |-> prdata[13:12] == 2'h1;
    endproperty
    a_const_flags: assert property (p_const_flags) else $error("constant flags wrong");
    property p_dout_cause;
        !$stable(dout) |-> $past(done_c && pwrite && (paddr == OFS_INSTR || paddr == OFS_REFRESH));
    endproperty
    a_dout_cause: assert property (p_dout_cause) else $error("output pins moved without cause");
    property p_imm_byte;
        done_c && pwrite && paddr == OFS_INSTR && (pwdata[7:0] & 8'hfe) == 8'h66
        |=> ((dout ^ $past(dout)) & ($past(pwdata[11]) ? 16'h00ff : 16'hff00)) == 16'h0000;
    endproperty
    a_imm_byte: assert property (p_imm_byte) else $error("immediate coil touched other byte");
    property p_irq_clear;
        done_c && !pwrite && paddr == OFS_IRQ_STAT |-> ##2 !irq;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("irq stays after status read");
endmodule : blsi_monitor
bind blsi_top blsi_monitor u_mon (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dout(dout), .irq(irq));
`default_nettype wire

// ---- tb/blsi_io_term.sv ----
/*
 * Built-in input terminal model.
 * Assumes the bench sets drive_val just after a rising edge.
 */
`timescale 1ns/100ps
`default_nettype none
module blsi_io_term (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [blsi_pkg::IMG_W-1:0] drive_val,
    output logic [blsi_pkg::IMG_W-1:0] din
);
    import blsi_pkg::*;
    // Pins settle one edge after the bench sets them
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            din <= '0;
        end else begin
            din <= drive_val;
        end
    end
endmodule : blsi_io_term
`default_nettype wire

// ---- tb/tb.sv ----
/*
 * Self-checking bench for blsi_top over APB.
 * Assumes the checker is bound and the terminal model drives din.
 */
`timescale 1ns/100ps
`default_nettype none
module tb;
    import blsi_pkg::*;
    typedef struct packed {logic [31:0] val; logic [31:0] msk; logic err;} blsi_note_s;
    logic mclk, resetn, psel, penable, pwrite, pready, pslverr, irq, cond, prev, v;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, fl;
    logic [IMG_W-1:0] din, dout, drive_val, p1, w;
    logic [3:0] b;
    logic [2:0] op;
    logic [1:0] em;
    int num_errors = 0;
    int checks = 0;
    blsi_note_s notes[$];
    blsi_note_s nt;

    blsi_top dut (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .din(din), .dout(dout), .irq(irq));
    blsi_io_term u_io (.mclk(mclk), .resetn(resetn), .drive_val(drive_val), .din(din));

    // ****
    // Compare, verdict and bus tasks
    // ****
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic print_verdict();
        if (num_errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m, input logic err);
        int n;
        n = 0;
        notes.push_back('{d & m, m, err});
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            num_errors++;
            print_verdict();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        apb(1'b0, a, e, m, 1'b0);
    endtask : rd
    task automatic st(input logic e);
        rd(OFS_STATUS, {31'h0, e}, 32'h1);
    endtask : st
    task automatic ex(input logic [2:0] o, input logic [1:0] e, input logic imm,
                      input logic [1:0] ar, input logic [3:0] bi, input logic [2:0] sl);
        wr(OFS_INSTR, {17'h0, sl, bi, ar, imm, e, o});
    endtask : ex

    // Transfer results matched against the oldest note
    always @(posedge mclk) begin
        if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
            nt = notes.pop_front();
            chk({31'h0, pslverr}, {31'h0, nt.err});
            chk(prdata & nt.msk, nt.val);
        end
    end
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // ****
    // Main sequence
    // ****
    initial begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        drive_val = 16'h0000;
        cond = 1'b0;
        void'($urandom(32'h0000_cb1d));
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        rd(OFS_FLAGS, 32'h0000_1000, 32'hffff_ffff);
        fl = $urandom;
        wr(OFS_FLAGS, fl);
        fl = (fl & 32'h0000_0fff) | 32'h0000_1000;
        rd(OFS_FLAGS, fl, 32'hffff_ffff);
        p1 = 16'($urandom);
        drive_val <= p1;
        wr(OFS_REFRESH, 32'h0);
        rd(OFS_IMG_IN, {16'h0, p1}, 32'hffff_ffff);
        drive_val <= ~p1;
        // Every non-edge contact form on the stale image
        for (int i = 0; i < 12; i++) begin
            b = 4'($urandom);
            op = 3'(i % 6);
            case (op)
                3'h0: cond = p1[b];
                3'h1: cond = !p1[b];
                3'h2: cond = cond & p1[b];
                3'h3: cond = cond & !p1[b];
                3'h4: cond = cond | p1[b];
                default: cond = cond | !p1[b];
            endcase
            ex(op, EDGE_NONE, 1'b0, AREA_IN, b, 3'h0);
            st(cond);
        end
        rd(OFS_FLAGS, fl, 32'hffff_ffff);
        ex(OP_LOAD, EDGE_NONE, 1'b1, AREA_IN, 4'ha, 3'h0);
        st(~p1[10]);
        rd(OFS_IMG_IN, {16'h0, ~p1[15:8], p1[7:0]}, 32'hffff_ffff);
        // Ordinary and immediate coils
        w = 16'($urandom) | 16'h0001;
        wr(OFS_WORK, {16'h0, w});
        ex(OP_LOAD, EDGE_NONE, 1'b0, AREA_WORK, 4'h0, 3'h0);
        ex(OP_COIL, EDGE_NONE, 1'b0, AREA_OUT, 4'h3, 3'h0);
        ex(OP_COIL_INV, EDGE_NONE, 1'b0, AREA_OUT, 4'hc, 3'h0);
        rd(OFS_IMG_OUT, 32'h0000_0008, 32'hffff_ffff);
        @(negedge mclk);
        chk(dout, 32'h0);
        wr(OFS_REFRESH, 32'h0);
        @(negedge mclk);
        chk(dout, 32'h0008);
        ex(OP_COIL, EDGE_NONE, 1'b0, AREA_OUT, 4'he, 3'h0);
        ex(OP_COIL, EDGE_NONE, 1'b0, AREA_OUT, 4'h2, 3'h0);
        ex(OP_COIL_INV, EDGE_NONE, 1'b1, AREA_OUT, 4'h9, 3'h0);
        @(negedge mclk);
        chk(dout, 32'h4008);
        ex(OP_LOAD, EDGE_NONE, 1'b0, AREA_OUT, 4'he, 3'h0);
        st(1'b1);
        ex(OP_SERIES_INV, EDGE_NONE, 1'b0, AREA_OUT, 4'h3, 3'h0);
        st(1'b0);
        // Edge forms, one history slot each
        for (int k = 0; k < 6; k++) begin
            op = 3'(2 * (k / 2));
            em = (k % 2 == 0) ? EDGE_UP : EDGE_DOWN;
            prev = 1'b0;
            for (int j = 0; j < 5; j++) begin
                v = (j != 2);
                wr(OFS_WORK, {30'h0, 1'b1, v});
                ex((op == OP_PAR) ? OP_LOAD_INV : OP_LOAD, EDGE_NONE, 1'b0, AREA_WORK, 4'h1, 3'h0);
                ex(op, em, 1'b0, AREA_WORK, 4'h0, 3'(k));
                st((em == EDGE_UP) ? (v & !prev) : (!v & prev));
                prev = v;
            end
        end
        // Immediate rising form on slot 7, falling form on slot 6
        for (int j = 0; j < 6; j++) begin
            drive_val <= ((j % 3 == 1) ^ (j > 2)) ? 16'h0010 : 16'h0000;
            ex(OP_LOAD, (j > 2) ? EDGE_DOWN : EDGE_UP, 1'b1, AREA_IN, 4'h4, (j > 2) ? 3'h6 : 3'h7);
            st(j % 3 == 1);
        end
        // Refused words and the interrupt
        rd(OFS_IRQ_STAT, 32'h0, 32'h0);
        wr(OFS_IRQ_MASK, 32'h0000_0002);
        ex(OP_LOAD_INV, EDGE_UP, 1'b0, AREA_IN, 4'h0, 3'h0);
        rd(OFS_STATUS, 32'h0000_0002, 32'h0000_0003);
        @(negedge mclk);
        chk(irq, 32'h1);
        rd(OFS_IRQ_STAT, 32'h0000_0002, 32'h0000_0002);
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk(irq, 32'h0);
        ex(OP_COIL, EDGE_DOWN, 1'b0, AREA_OUT, 4'h0, 3'h0);
        rd(OFS_STATUS, 32'h0000_0002, 32'h0000_0002);
        ex(OP_SERIES, EDGE_NONE, 1'b1, AREA_EXP, 4'h0, 3'h0);
        rd(OFS_STATUS, 32'h0000_0002, 32'h0000_0002);
        ex(OP_PAR, EDGE_BAD, 1'b0, AREA_IN, 4'h0, 3'h0);
        rd(OFS_STATUS, 32'h0000_0002, 32'h0000_0002);
        apb(1'b0, 8'h24, 32'h0, 32'hffff_ffff, 1'b1);
        apb(1'b1, 8'h06, 32'h0, 32'h0, 1'b1);
        rd(OFS_IRQ_STAT, 32'h0, 32'h0);
        ex(OP_LOAD, EDGE_NONE, 1'b0, AREA_IN, 4'h0, 3'h0);
        @(negedge mclk);
        chk(irq, 32'h0);
        print_verdict();
    end
endmodule : tb
`default_nettype wire
